// >>> frb_top.sv
// repair header builder: package, register slave and parity datapath
package frb_pkg;
  localparam int          CLK_NS      = 50;
  localparam int          TS_TICK_NS  = 1000;
  localparam int          TS_TICK_CYC = (TS_TICK_NS + CLK_NS - 1) / CLK_NS;
  localparam int          MEM_AW      = 6;
  localparam int          MEM_DEPTH   = 64;
  localparam int          HDR_WORDS   = 3;
  localparam int          MASK_BITS   = 110;
  localparam logic [1:0]  RTP_VER     = 2'h2;
  localparam logic [1:0]  FEC_RF      = 2'h0;
  localparam logic [3:0]  REP_CC      = 4'h1;
  localparam logic [31:0] LFSR_SEED   = 32'h0000_0001;
  localparam logic [31:0] LFSR_TAPS   = 32'h8020_0003;
  localparam logic [7:0]  A_CTRL      = 8'h00;
  localparam logic [7:0]  A_SRC_SSRC  = 8'h04;
  localparam logic [7:0]  A_REP_SSRC  = 8'h08;
  localparam logic [7:0]  A_SEQ_BASE  = 8'h0c;
  localparam logic [7:0]  A_MASK0     = 8'h10;
  localparam logic [7:0]  A_MASK3     = 8'h1c;
  localparam logic [7:0]  A_STAT      = 8'h20;
  localparam logic [7:0]  A_TS        = 8'h24;
  localparam int          C_EN        = 0;
  localparam int          C_EMIT      = 1;
  localparam int          C_MSEL      = 2;
  localparam int          C_PAD       = 4;
  localparam int          C_EXT       = 5;
  localparam int          C_PT        = 6;
  localparam int          S_COLL      = 1;
  localparam logic [1:0]  RESP_OK     = 2'h0;
  localparam logic [1:0]  RESP_ERR    = 2'h2;

  typedef struct packed {
    logic        valid;
    logic        last;
    logic [31:0] data;
  } frb_beat_t;

  typedef enum logic [1:0] {ST_IDLE, ST_HDR, ST_PAY, ST_TAIL} frb_state_t;

  function automatic logic [6:0] frb_mask_len(input logic [1:0] sel);
    case (sel)
      2'h0:    return 7'h0f;
      2'h1:    return 7'h2e;
      default: return 7'h6e;
    endcase
  endfunction

  function automatic logic [3:0] frb_mask_words(input logic [1:0] sel);
    case (sel)
      2'h0:    return 4'h1;
      2'h1:    return 4'h2;
      default: return 4'h4;
    endcase
  endfunction

  // index 0 of the mask is its most significant bit
  function automatic logic frb_in_mask(input logic [15:0] s,
                                       input logic [15:0] base,
                                       input logic [MASK_BITS-1:0] m,
                                       input logic [1:0] sel);
    logic [15:0] off;
    off = s - base;
    if (off >= {9'h000, frb_mask_len(sel)}) return 1'b0;
    return m[7'(MASK_BITS - 1) - off[6:0]];
  endfunction

  function automatic logic [31:0] frb_wstrb(input logic [31:0] old,
                                            input logic [31:0] d,
                                            input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) r[i*8 +: 8] = d[i*8 +: 8];
    end
    return r;
  endfunction

  function automatic logic frb_mapped(input logic [7:0] a);
    return (a[1:0] == 2'h0) && (a <= A_TS);
  endfunction
endpackage

`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - repair and source packets use version 2
// - marker sent zero; receivers ignore it
// - repair sequence steps by one per packet
// - starting sequence number taken unpredictably
// - timestamp reflects repair transmission time
// - count and list name protected source SSRC
// - payload parity covers octets past twelve bytes
// - mask width is 15, 46 or 110
// - mask bit i protects base plus i
// - repair stream gets a random SSRC
// - repair padding independent of source padding
// - repair extension independent of source extension
// - protected packets share one session
// - source packets forwarded unmodified
// - repair content is XOR of selected packets
// - SSRC collision resolved by reselection
// - first two header bits select variant
// - both variant bits never set together
// - row repair XORs consecutive packets; not built here, only mask-selected repair with variant bits zero
// - column repair XORs packets row-length apart; not built here, only mask-selected repair with variant bits zero
module frb_top
  import frb_pkg::*;
(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // register bus
  input  wire logic        awvalid,
  output var  logic        awready,
  input  wire logic [7:0]  awaddr,
  input  wire logic        wvalid,
  output var  logic        wready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  output var  logic        bvalid,
  input  wire logic        bready,
  output var  logic [1:0]  bresp,
  input  wire logic        arvalid,
  output var  logic        arready,
  input  wire logic [7:0]  araddr,
  output var  logic        rvalid,
  input  wire logic        rready,
  output var  logic [31:0] rdata,
  output var  logic [1:0]  rresp,
  // source stream in, forwarded source, repair stream
  input  wire frb_beat_t   src_in,
  output var  frb_beat_t   fwd_out,
  output var  frb_beat_t   rep_out
);

  default clocking dcb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  // ------------------------------------------------------------------
  // register slave
  // ------------------------------------------------------------------
  logic                 aw_v, next_aw_v, w_v, next_w_v;
  logic [7:0]           aw_a, next_aw_a;
  logic [31:0]          w_d, next_w_d;
  logic [3:0]           w_s, next_w_s;
  logic                 next_awready, next_wready, next_bvalid;
  logic                 next_arready, next_rvalid;
  logic [1:0]           next_bresp, next_rresp;
  logic [31:0]          next_rdata, rd_val;
  logic                 wr_fire;
  logic [31:0]          ctrl, next_ctrl, src_ssrc, next_src_ssrc;
  logic [15:0]          seq_base, next_seq_base;
  logic [MASK_BITS-1:0] mask, next_mask;
  // datapath state read by the slave
  logic [31:0]          rep_ssrc, ts_cnt;
  logic [15:0]          seq;
  logic                 coll;
  frb_state_t           st;

  always_comb begin
    next_aw_v = aw_v;   next_aw_a = aw_a;
    next_w_v = w_v;     next_w_d = w_d;     next_w_s = w_s;
    next_bvalid = bvalid;  next_bresp = bresp;
    next_rvalid = rvalid;  next_rdata = rdata;  next_rresp = rresp;
    next_ctrl = ctrl;   next_src_ssrc = src_ssrc;
    next_seq_base = seq_base;  next_mask = mask;
    case (araddr)
      A_CTRL:     rd_val = ctrl;
      A_SRC_SSRC: rd_val = src_ssrc;
      A_REP_SSRC: rd_val = rep_ssrc;
      A_SEQ_BASE: rd_val = {16'h0000, seq_base};
      8'h10:      rd_val = {18'h00000, mask[109:96]};
      8'h14:      rd_val = mask[95:64];
      8'h18:      rd_val = mask[63:32];
      A_MASK3:    rd_val = mask[31:0];
      A_STAT:     rd_val = {seq, 14'h0000, coll, st != ST_IDLE};
      A_TS:       rd_val = ts_cnt;
      default:    rd_val = 32'h0000_0000;
    endcase
    if (awvalid && awready) begin
      next_aw_v = 1'b1;
      next_aw_a = awaddr;
    end
    if (wvalid && wready) begin
      next_w_v = 1'b1;
      next_w_d = wdata;
      next_w_s = wstrb;
    end
    if (bvalid && bready) next_bvalid = 1'b0;
    wr_fire = aw_v && w_v && !bvalid;
    if (wr_fire) begin
      next_aw_v = 1'b0;
      next_w_v = 1'b0;
      next_bvalid = 1'b1;
      next_bresp = frb_mapped(aw_a) ? RESP_OK : RESP_ERR;
      case (aw_a)
        A_CTRL:     next_ctrl = frb_wstrb(ctrl, w_d, w_s) &
                                32'h0000_1ffd;
        A_SRC_SSRC: next_src_ssrc = frb_wstrb(src_ssrc, w_d, w_s);
        A_SEQ_BASE: next_seq_base = 16'(frb_wstrb({16'h0000, seq_base},
                                                  w_d, w_s));
        8'h10:      next_mask[109:96] =
                      14'(frb_wstrb({18'h00000, mask[109:96]}, w_d, w_s));
        8'h14:      next_mask[95:64] = frb_wstrb(mask[95:64], w_d, w_s);
        8'h18:      next_mask[63:32] = frb_wstrb(mask[63:32], w_d, w_s);
        A_MASK3:    next_mask[31:0] = frb_wstrb(mask[31:0], w_d, w_s);
        default:    ;
      endcase
      if (next_ctrl[C_MSEL +: 2] == 2'h3) next_ctrl[C_MSEL +: 2] = 2'h2;
    end
    next_awready = !next_aw_v;
    next_wready = !next_w_v;
    if (rvalid && rready) next_rvalid = 1'b0;
    if (arvalid && arready) begin
      next_rvalid = 1'b1;
      next_rdata = rd_val;
      next_rresp = frb_mapped(araddr) ? RESP_OK : RESP_ERR;
    end
    next_arready = !next_rvalid;
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      aw_v <= 1'b0;  aw_a <= 8'h00;  w_v <= 1'b0;
      w_d <= 32'h0000_0000;  w_s <= 4'h0;
      awready <= 1'b1;  wready <= 1'b1;  arready <= 1'b1;
      bvalid <= 1'b0;  bresp <= RESP_OK;
      rvalid <= 1'b0;  rdata <= 32'h0000_0000;  rresp <= RESP_OK;
      ctrl <= 32'h0000_0000;  src_ssrc <= 32'h0000_0000;
      seq_base <= 16'h0000;  mask <= '0;
    end else begin
      aw_v <= next_aw_v;  aw_a <= next_aw_a;  w_v <= next_w_v;
      w_d <= next_w_d;  w_s <= next_w_s;
      awready <= next_awready;  wready <= next_wready;
      arready <= next_arready;
      bvalid <= next_bvalid;  bresp <= next_bresp;
      rvalid <= next_rvalid;  rdata <= next_rdata;  rresp <= next_rresp;
      ctrl <= next_ctrl;  src_ssrc <= next_src_ssrc;
      seq_base <= next_seq_base;  mask <= next_mask;
    end
  end

  // ------------------------------------------------------------------
  // source accumulation and repair emission
  // ------------------------------------------------------------------
  logic [31:0]       lfsr, next_lfsr, next_rep_ssrc, next_ts_cnt;
  logic [31:0]       cap_ts, next_cap_ts, rec_ts, next_rec_ts;
  logic [31:0]       ts_cap, next_ts_cap, pend_d, next_pend_d, hw;
  logic [31:0]       mem_wd, mem_rd;
  logic [15:0]       cap_w0, next_cap_w0, rec_len, next_rec_len;
  logic [15:0]       cap_sq, next_cap_sq;
  logic [15:0]       next_seq;
  logic [13:0]       rec_hdr, next_rec_hdr;
  logic [7:0]        ts_div, next_ts_div, widx, next_widx;
  logic [6:0]        acc_len, next_acc_len, words;
  logic [5:0]        pend_a, next_pend_a, pcnt, next_pcnt, mem_ra;
  logic [3:0]        hcnt, next_hcnt, hdr_last;
  logic              pend_v, next_pend_v, prot, next_prot, prot_now;
  logic              pend_old, next_pend_old;
  logic              emit_req, next_emit_req, en_q, next_coll;
  logic              pay_v, next_pay_v, pay_l, next_pay_l, coll_ev;
  frb_state_t        next_st;
  frb_beat_t         next_fwd, next_rep;

  assign hdr_last = 4'h5 + frb_mask_words(ctrl[C_MSEL +: 2]);
  // fold in the stored word only where an earlier packet already wrote it
  assign mem_wd = pend_d ^ (pend_old ? mem_rd : 32'h0);

  frb_par_mem u_mem (
    .clk     (clk),
    .wr_en   (pend_v),
    .wr_addr (pend_a),
    .wr_data (mem_wd),
    .rd_addr (mem_ra),
    .rd_data (mem_rd)
  );

  always_comb begin
    next_lfsr = lfsr[0] ? ((lfsr >> 1) ^ LFSR_TAPS) : (lfsr >> 1);
    next_ts_div = ts_div + 8'h01;
    next_ts_cnt = ts_cnt;
    if (ts_div == 8'(TS_TICK_CYC - 1)) begin
      next_ts_div = 8'h00;
      next_ts_cnt = ts_cnt + 32'h1;
    end
    next_seq = seq;  next_rep_ssrc = rep_ssrc;  next_coll = coll;
    next_cap_w0 = cap_w0;  next_cap_ts = cap_ts;  next_prot = prot;
    next_rec_hdr = rec_hdr;  next_rec_ts = rec_ts;  next_rec_len = rec_len;
    next_acc_len = acc_len;  next_widx = widx;
    next_cap_sq = cap_sq;
    next_pend_old = pend_old;
    next_pend_v = 1'b0;  next_pend_a = pend_a;  next_pend_d = pend_d;
    next_st = st;  next_hcnt = hcnt;  next_pcnt = pcnt;  next_ts_cap = ts_cap;
    next_emit_req = emit_req;  next_pay_v = 1'b0;  next_pay_l = 1'b0;
    mem_ra = 6'(widx - 8'(HDR_WORDS));
    coll_ev = 1'b0;  words = 7'h00;  prot_now = prot;
    next_fwd = src_in;
    next_rep = '{valid: 1'b0, last: 1'b0, data: 32'h0000_0000};
    if (ctrl[C_EN] && !en_q) next_seq = lfsr[15:0];
    if (wr_fire && aw_a == A_CTRL && w_d[C_EMIT] && w_s[0]) begin
      next_emit_req = 1'b1;
    end
    if (wr_fire && aw_a == A_REP_SSRC) begin
      next_rep_ssrc = frb_wstrb(rep_ssrc, w_d, w_s);
    end
    if (wr_fire && aw_a == A_STAT && w_d[S_COLL] && w_s[0]) begin
      next_coll = 1'b0;
    end
    // parity gathering; packets whose third word arrives while busy stay unprotected
    if (src_in.valid) begin
      next_widx = src_in.last ? 8'h00 : (widx == 8'hff ? widx : widx + 8'h01);
      case (widx)
        8'h00: begin
          next_cap_w0 = src_in.data[31:16];
          next_cap_sq = src_in.data[15:0];
        end
        8'h01: next_cap_ts = src_in.data;
        8'h02: begin
          prot_now = ctrl[C_EN] && st == ST_IDLE &&
                     src_in.data == src_ssrc &&
                     cap_w0[15:14] == RTP_VER &&
                     frb_in_mask(cap_sq, seq_base, mask,
                                 ctrl[C_MSEL +: 2]);
          next_prot = prot_now;
          if (src_in.data == rep_ssrc) begin
            coll_ev = 1'b1;
            next_rep_ssrc = lfsr;
            next_coll = 1'b1;
          end
          if (prot_now) begin
            next_rec_hdr = rec_hdr ^ cap_w0[13:0];
            next_rec_ts = rec_ts ^ cap_ts;
          end
        end
        default: begin
          if (prot && widx < 8'(HDR_WORDS + MEM_DEPTH)) begin
            next_pend_v = 1'b1;
            next_pend_a = mem_ra;
            next_pend_d = src_in.data;
            next_pend_old = {1'b0, mem_ra} < acc_len;
          end
        end
      endcase
      if (src_in.last && prot_now && widx >= 8'h02) begin
        words = (widx > 8'(HDR_WORDS + MEM_DEPTH - 1)) ? 7'(MEM_DEPTH) :
                7'(widx - 8'h02);
        next_rec_len = rec_len ^ 16'((widx - 8'h02) << 2);
        if (words > acc_len) next_acc_len = words;
      end
      if (src_in.last) next_prot = 1'b0;
    end
    case (hcnt)
      4'h0: hw = {RTP_VER, ctrl[C_PAD], ctrl[C_EXT], REP_CC,
                  1'b0, ctrl[C_PT +: 7], seq};
      4'h1: hw = ts_cap;
      4'h2: hw = rep_ssrc;
      4'h3: hw = src_ssrc;
      4'h4: hw = {FEC_RF, rec_hdr, rec_len};
      4'h5: hw = rec_ts;
      4'h6: hw = {seq_base, ctrl[C_MSEL +: 2] != 2'h0, mask[109:95]};
      4'h7: hw = {ctrl[C_MSEL +: 2] == 2'h2, mask[94:64]};
      4'h8: hw = mask[63:32];
      default: hw = mask[31:0];
    endcase
    if (pay_v) next_rep = '{valid: 1'b1, last: pay_l, data: mem_rd};
    case (st)
      ST_IDLE: begin
        if (emit_req && widx == 8'h00 && !pend_v && !src_in.valid) begin
          next_emit_req = 1'b0;
          next_st = ST_HDR;
          next_hcnt = 4'h0;
          next_ts_cap = ts_cnt;
        end
      end
      ST_HDR: begin
        next_rep = '{valid: 1'b1,
                     last: hcnt == hdr_last && acc_len == 7'h00,
                     data: hw};
        if (hcnt == 4'h0) next_seq = seq + 16'h0001;
        next_hcnt = hcnt + 4'h1;
        if (hcnt == hdr_last) begin
          next_pcnt = 6'h00;
          next_st = (acc_len == 7'h00) ? ST_TAIL : ST_PAY;
        end
      end
      ST_PAY: begin
        mem_ra = pcnt;
        next_pay_v = 1'b1;
        next_pay_l = {1'b0, pcnt} + 7'h01 == acc_len;
        next_pcnt = pcnt + 6'h01;
        if (next_pay_l) next_st = ST_TAIL;
      end
      ST_TAIL: begin
        // block finished: next repair starts a fresh source group
        next_acc_len = 7'h00;
        next_rec_hdr = 14'h0000;
        next_rec_len = 16'h0000;
        next_rec_ts = 32'h0000_0000;
        next_st = ST_IDLE;
      end
      default: next_st = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      lfsr <= LFSR_SEED;  ts_div <= 8'h00;
      ts_cnt <= 32'h0000_0000;  seq <= 16'h0000;
      rep_ssrc <= 32'h0000_0000;  coll <= 1'b0;
      cap_w0 <= 16'h0000;  cap_sq <= 16'h0000;
      cap_ts <= 32'h0000_0000;  prot <= 1'b0;
      rec_hdr <= 14'h0000;  rec_ts <= 32'h0000_0000;
      rec_len <= 16'h0000;  acc_len <= 7'h00;
      widx <= 8'h00;  pend_v <= 1'b0;
      pend_a <= 6'h00;  pend_d <= 32'h0000_0000;
      pend_old <= 1'b0;  st <= ST_IDLE;
      hcnt <= 4'h0;  pcnt <= 6'h00;
      ts_cap <= 32'h0000_0000;  emit_req <= 1'b0;
      pay_v <= 1'b0;  pay_l <= 1'b0;
      en_q <= 1'b0;  fwd_out <= '0;
      rep_out <= '0;
    end else begin
      lfsr <= next_lfsr;  ts_div <= next_ts_div;
      ts_cnt <= next_ts_cnt;  seq <= next_seq;
      rep_ssrc <= next_rep_ssrc;  coll <= next_coll;
      cap_w0 <= next_cap_w0;  cap_sq <= next_cap_sq;
      cap_ts <= next_cap_ts;  prot <= next_prot;
      rec_hdr <= next_rec_hdr;  rec_ts <= next_rec_ts;
      rec_len <= next_rec_len;  acc_len <= next_acc_len;
      widx <= next_widx;  pend_v <= next_pend_v;
      pend_a <= next_pend_a;  pend_d <= next_pend_d;
      pend_old <= next_pend_old;  st <= next_st;
      hcnt <= next_hcnt;  pcnt <= next_pcnt;
      ts_cap <= next_ts_cap;  emit_req <= next_emit_req;
      pay_v <= next_pay_v;  pay_l <= next_pay_l;
      en_q <= ctrl[C_EN];  fwd_out <= next_fwd;
      rep_out <= next_rep;
    end
  end

  // ------------------------------------------------------------------
  // checks on the repair header, forwarding, collision flag, time counter and mask select
  // ------------------------------------------------------------------
  sequence hdr_start_s;
    st == ST_HDR && hcnt == 4'h0;
  endsequence

  sequence fec_word_s;
    st == ST_HDR && hcnt == 4'h4;
  endsequence

  ver_marker_a: assert property (hdr_start_s |=>
    rep_out.valid && rep_out.data[31:30] == RTP_VER && !rep_out.data[23])
    else $error("repair header version or marker wrong");

  seq_step_a: assert property (hdr_start_s |=>
    seq == 16'($past(seq) + 16'h0001))
    else $error("repair sequence did not step by one");

  rf_bits_a: assert property (fec_word_s |=>
    rep_out.data[31:30] == FEC_RF && rep_out.data[31:30] != 2'h3)
    else $error("variant bits wrong");

  fwd_copy_a: assert property (1'b1 |=>
    fwd_out == $past(src_in))
    else $error("source stream altered on forwarding");

  coll_set_a: assert property (coll_ev |=> coll)
    else $error("identity clash not flagged");

  ts_tick_a: assert property (ts_div == 8'(TS_TICK_CYC - 1) |=>
    ts_cnt == $past(ts_cnt) + 32'h1)
    else $error("time counter missed a tick");

  msel_legal_a: assert property (ctrl[C_MSEL +: 2] != 2'h3)
    else $error("mask width select holds an illegal code");
endmodule
`default_nettype wire

// >>> frb_par_mem.sv
// parity accumulation memory: one write port, one registered read port
`timescale 1ns/1ps
`default_nettype none
module frb_par_mem
  import frb_pkg::*;
(
  // clock
  input  wire logic                clk,
  // write port
  input  wire logic                wr_en,
  input  wire logic [MEM_AW-1:0]   wr_addr,
  input  wire logic [31:0]         wr_data,
  // read port
  input  wire logic [MEM_AW-1:0]   rd_addr,
  output var  logic [31:0]         rd_data
);

  logic [31:0] mem [MEM_DEPTH];

  // no reset on the array; stale words are masked by the valid length
  always_ff @(posedge clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
    rd_data <= mem[rd_addr];
  end

endmodule
`default_nettype wire

// >>> frb_rx_model.sv
// receiving end of the repair stream: parses and keeps repair headers
`timescale 1ns/1ps
`default_nettype none
module frb_rx_model
  import frb_pkg::*;
(
  // clock and reset
  input  wire logic             clk,
  input  wire logic             rst_n,
  // repair stream and the payload type this end knows
  input  wire frb_beat_t        rep_in,
  input  wire logic [6:0]       known_pt,
  // fields of the last accepted packet, and accepted, dropped and out-of-sequence counts
  output var  logic [3:0][31:0] hdr,
  output var  logic [31:0]      tail,
  output var  logic [15:0]      n_pkt,
  output var  logic [15:0]      n_drop,
  output var  logic [15:0]      seq_err
);
  logic [3:0][31:0] cur;
  logic [2:0]       idx;
  logic [15:0]      last_seq;
  logic             have_seq;

  // marker bit is never looked at here
  always @(posedge clk) begin
    if (!rst_n) begin
      idx = 3'h0;
      have_seq = 1'b0;
      n_pkt <= 16'h0;
      n_drop <= 16'h0;
      seq_err <= 16'h0;
    end else if (rep_in.valid) begin
      if (idx < 3'h4) cur[idx[1:0]] = rep_in.data;
      if (idx < 3'h4) idx = idx + 3'h1;
      if (rep_in.last) begin
        idx = 3'h0;
        if (cur[0][22:16] !== known_pt) begin
          n_drop <= n_drop + 16'h1;
        end else begin
          if (have_seq && cur[0][15:0] !== 16'(last_seq + 16'h1)) begin
            seq_err <= seq_err + 16'h1;
          end
          last_seq = cur[0][15:0];
          have_seq = 1'b1;
          hdr <= cur;
          tail <= rep_in.data;
          n_pkt <= n_pkt + 16'h1;
        end
      end
    end
  end
endmodule
`default_nettype wire

// >>> tb_fec_repair_rtp_header_builder.sv
// register-driven bench for the repair header builder
`timescale 1ns/1ps
`default_nettype none
module tb_fec_repair_rtp_header_builder
  import frb_pkg::*;
;
  logic             clk, rst_n;
  logic             awvalid, awready, wvalid, wready, bvalid, bready;
  logic             arvalid, arready, rvalid, rready;
  logic [7:0]       awaddr, araddr;
  logic [31:0]      wdata, rdata, d, x, pay, ctl, ts_prev;
  logic [3:0]       wstrb;
  logic [1:0]       bresp, rresp, r;
  logic [15:0]      base, seq_prev, n0;
  logic [6:0]       known_pt;
  frb_beat_t        src_in, fwd_out, rep_out, fw;
  frb_beat_t        fwd_q[$];
  logic [3:0][31:0] hdr;
  logic [31:0]      tail;
  logic [15:0]      n_pkt, n_drop, seq_err;
  int               bad_count, compares, ln, t;
  localparam logic [31:0] SRC_ID = 32'h5eed_0001; // arbitrary
  localparam logic [31:0] REP_ID = 32'h0bad_0c0d; // arbitrary

  always #25 clk = ~clk;

  frb_top u_dut (
    .clk(clk), .rst_n(rst_n),
    .awvalid(awvalid), .awready(awready), .awaddr(awaddr),
    .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
    .bvalid(bvalid), .bready(bready), .bresp(bresp),
    .arvalid(arvalid), .arready(arready), .araddr(araddr),
    .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
    .src_in(src_in), .fwd_out(fwd_out), .rep_out(rep_out)
  );

  frb_rx_model u_rx (
    .clk(clk), .rst_n(rst_n), .rep_in(rep_out), .known_pt(known_pt),
    .hdr(hdr), .tail(tail), .n_pkt(n_pkt), .n_drop(n_drop),
    .seq_err(seq_err)
  );

  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    awvalid <= 1'b1;
    awaddr <= a;
    wvalid <= 1'b1;
    wdata <= v;
    bready <= 1'b1;
    do begin
      @(posedge clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    r = bresp;
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    arvalid <= 1'b1;
    araddr <= a;
    rready <= 1'b1;
    do begin
      @(posedge clk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask

  // source packet: version 2, no padding, extension set, one payload word
  task automatic send(input logic [15:0] sq, input logic [31:0] p);
    logic [31:0] w[4];
    w = '{{2'h2, 1'b0, 1'b1, 4'h0, 1'b0, 7'h60, sq}, {16'h0, sq}, SRC_ID, p};
    for (int i = 0; i < 4; i++) begin
      @(posedge clk);
      src_in <= '{1'b1, i == 3, w[i]};
      fwd_q.push_back('{1'b1, i == 3, w[i]});
    end
    @(posedge clk);
    src_in <= '0;
  endtask

  task automatic summarize();
    if (bad_count == 0 && compares > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  // forwarded source stream must match what went in, word for word
  always @(posedge clk) begin
    if (rst_n && fwd_out.valid) begin
      if (fwd_q.size() == 0) chk(32'h1, 32'h0);
      else begin
        fw = fwd_q.pop_front();
        chk(fwd_out.data, fw.data);
        chk(32'(fwd_out.last), 32'(fw.last));
      end
    end
  end

  initial begin
    repeat (20000) @(posedge clk);
    bad_count++;
    summarize();
  end

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    clk = 1'b0;
    rst_n = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    awaddr = '0;
    araddr = '0;
    wdata = '0;
    wstrb = 4'hf;
    src_in = '0;
    known_pt = 7'h61;
    bad_count = 0;
    compares = 0;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    rd(A_CTRL);
    chk(d, 32'h0);
    wr(A_SRC_SSRC, SRC_ID);
    rd(A_SRC_SSRC);
    chk(d, SRC_ID);
    // unmapped and misaligned places answer with an error
    rd(8'h28);
    chk(32'(r), 32'(RESP_ERR));
    rd(8'h06);
    chk(32'(r), 32'(RESP_ERR));
    wr(8'h40, 32'h1);
    chk(32'(r), 32'(RESP_ERR));
    // repair identity equal to the source identity is a collision
    wr(A_REP_SSRC, SRC_ID);
    send(16'h0100, 32'h0);
    rd(A_STAT);
    chk(32'(d[S_COLL]), 32'h1);
    rd(A_REP_SSRC);
    chk(32'(d != SRC_ID), 32'h1);
    wr(A_STAT, 32'h2);
    rd(A_STAT);
    chk(32'(d[S_COLL]), 32'h0);
    wr(A_REP_SSRC, REP_ID);
    rd(A_REP_SSRC);
    chk(d, REP_ID);
    for (int i = 0; i < 4; i++) wr(A_MASK0 + 8'(4 * i), 32'hffff_ffff);
    // one packet past the mask's end must stay out of the parity
    for (int s = 0; s < 3; s++) begin
      ln = s == 0 ? 15 : s == 1 ? 46 : 110;
      base = s == 0 ? 16'hfff8 : 16'(16'h0200 * s);
      ctl = {19'h0, 7'h61, 2'b01, 2'(s), 2'b01};
      wr(A_SEQ_BASE, {16'h0, base});
      rd(A_SEQ_BASE);
      chk(d, {16'h0, base});
      wr(A_CTRL, ctl);
      x = 32'h0;
      for (int i = 0; i <= ln; i++) begin
        pay = 32'(32'h1357_9bdf * (i + 1)) ^ 32'(s);
        send(16'(base + 16'(i)), pay);
        if (i < ln) x ^= pay;
      end
      n0 = n_pkt;
      wr(A_CTRL, ctl | 32'h2);
      t = 0;
      while (n_pkt == n0 && t < 2000) begin
        @(posedge clk);
        t++;
      end
      chk(32'(n_pkt - n0), 32'h1);
      chk(32'(hdr[0][31:30]), 32'(RTP_VER));
      chk(32'(hdr[0][23]), 32'h0);
      chk(32'(hdr[0][29:28]), 32'h2);
      chk(32'(hdr[0][27:24]), 32'(REP_CC));
      chk(hdr[2], REP_ID);
      chk(hdr[3], SRC_ID);
      chk(tail, x);
      if (s > 0) begin
        chk(32'(hdr[0][15:0]), 32'(16'(seq_prev + 16'h1)));
        chk(32'(hdr[1] != ts_prev), 32'h1);
      end
      seq_prev = hdr[0][15:0];
      ts_prev = hdr[1];
    end
    chk(32'(seq_err), 32'h0);
    chk(32'(n_drop), 32'h0);
    chk(32'(fwd_q.size()), 32'h0);
    summarize();
  end
endmodule
`default_nettype wire
